// ### hw/voltage_monitor_interrupt_logic.sv
// Supply monitors, protection flags and interrupt line of the power device
`timescale 1ns/100ps
`default_nettype none
`include "vmi_regs.svh"
module voltage_monitor_interrupt_logic
	import vmi_pkg::*;
#(
	parameter int  SHORT_TIME_NS = `SHORT_TIME_NS,
	parameter mv_t VSET_BASE_MV  = 16'h0000,
	parameter mv_t VSET_STEP_MV  = 16'h000A
) (
	// Clock and reset
	input  wire logic                     clock_i,
	input  wire logic                     reset_n_i,
	// Monitor settings
	input  wire logic                     window_type_select_i,
	input  wire logic [`RAIL_COUNT-1:0]   monitor_enable_control_i,
	input  wire logic [1:0][7:0]          stepdown_voltage_setting_i,
	input  wire logic [1:0][1:0]          stepdown_window_select_i,
	input  wire logic [1:0]               stepup_voltage_setting_i,
	input  wire logic [1:0]               stepup_window_select_i,
	input  wire logic                     input_nominal_select_i,
	input  wire logic [1:0]               input_window_select_i,
	input  wire logic [1:0][4:0]          extmon_nominal_select_i,
	input  wire logic [1:0][1:0]          extmon_window_select_i,
	// Measured rail levels, same clock
	input  wire mv_t [`RAIL_COUNT-1:0]    measured_mv_i,
	// Analog fault comparators, asynchronous
	input  wire faults_t                  faults_i,
	// Converter control
	input  wire logic [1:0]               stepdown_enable_req_i,
	input  wire logic                     stepup_enable_req_i,
	output logic      [1:0]               stepdown_enable_o,
	output logic                          stepup_enable_o,
	output logic                          general_purpose_outputs_low_o,
	output mv_t                           stepup_target_mv_o,
	output logic      [1:0]               extmon_high_z_o,
	output logic      [`RAIL_COUNT-1:0]   rail_valid_o,
	// Flags, masks and status
	input  wire flags_t                   clear_i,
	input  wire masks_t                   masks_i,
	output flags_t                        flags_o,
	output status_t                       status_o,
	output logic                          stepdown_converter_group_flag_o,
	output logic                          stepup_group_flag_o,
	output logic                          interrupt_out_n_o
);

	//------------------------------------------------------------
	// Timing
	//------------------------------------------------------------
	localparam int ILIM_CYC  = (`ILIM_DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int SHORT_CYC = (SHORT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int IW        = $clog2(ILIM_CYC + 1);
	localparam int SW        = $clog2(SHORT_CYC + 1);
	localparam int FW        = $bits(flags_t);

	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	faults_t sync1_q, sync2_q, fault_s;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= faults_i;
			sync2_q <= sync1_q;
		end
	end
	assign fault_s = sync2_q;

	//------------------------------------------------------------
	// Nominal levels and windows
	//------------------------------------------------------------
	mv_t [`RAIL_COUNT-1:0] nom_mv, win_mv;
	logic [`RAIL_COUNT-1:0] active, rv;
	mv_t ext_raw;

	always_comb begin
		ext_raw = '0;
		for (int i = 0; i < 2; i++) begin
			nom_mv[i] = mv_t'(VSET_BASE_MV
				+ mv_t'(stepdown_voltage_setting_i[i]) * VSET_STEP_MV);
			win_mv[i] = mv_t'(`SD_WIN_BASE_MV
				+ mv_t'(stepdown_window_select_i[i]) * `SD_WIN_STEP_MV);
		end
		nom_mv[`RAIL_SU] = mv_t'(`SU_NOM_BASE_MV
			+ mv_t'(stepup_voltage_setting_i) * `SU_NOM_STEP_MV);
		win_mv[`RAIL_SU] = percent_mv(nom_mv[`RAIL_SU], 7'(`SU_PCT_BASE
			+ 7'(stepup_window_select_i) * `SU_PCT_STEP));
		nom_mv[`RAIL_IN] = input_nominal_select_i ? `IN_NOM_HIGH_MV
			: `IN_NOM_LOW_MV;
		win_mv[`RAIL_IN] = percent_mv(nom_mv[`RAIL_IN], ext_pct(input_window_select_i));
		for (int j = 0; j < 2; j++) begin
			ext_raw = mv_t'(`EXT_NOM_MIN_MV
				+ mv_t'(extmon_nominal_select_i[j]) * `EXT_NOM_STEP_MV);
			nom_mv[`RAIL_EXT0+j] = (ext_raw > `EXT_NOM_MAX_MV) ? `EXT_NOM_MAX_MV
				: ext_raw;
			win_mv[`RAIL_EXT0+j] = percent_mv(nom_mv[`RAIL_EXT0+j],
				ext_pct(extmon_window_select_i[j]));
		end
	end

	// Converter rails only watched while the converter runs
	always_comb begin
		active = monitor_enable_control_i;
		active[0] = monitor_enable_control_i[0] && stepdown_enable_o[0];
		active[1] = monitor_enable_control_i[1] && stepdown_enable_o[1];
		active[`RAIL_SU] = monitor_enable_control_i[`RAIL_SU] && stepup_enable_o;
	end

	for (genvar r = 0; r < `RAIL_COUNT; r++) begin : g_rail
		window_check u_check (
			.clock_i       (clock_i),
			.reset_n_i     (reset_n_i),
			.active_i      (active[r]),
			.window_type_i (window_type_select_i),
			.nominal_i     (nom_mv[r]),
			.window_i      (win_mv[r]),
			.measured_i    (measured_mv_i[r]),
			.valid_o       (rv[r])
		);
	end

	// Lowest threshold code turns the pin into a divider input
	always_comb begin
		for (int j = 0; j < 2; j++) begin
			extmon_high_z_o[j] = (extmon_nominal_select_i[j] == 5'h00);
		end
	end

	//------------------------------------------------------------
	// Current limit debounce and short-circuit timing
	//------------------------------------------------------------
	logic [1:0][IW-1:0] ilim_cnt_q, ilim_cnt_d;
	logic [1:0][SW-1:0] short_cnt_q, short_cnt_d;
	logic [1:0]         sd_below, sd_trip, sd_off_q, sd_off_d, ilim_deb;
	logic               su_off_q, su_off_d, su_trip, shutdown_all;

	// Kept out of the counter process so the enables do not loop through it
	assign shutdown_all = fault_s.t_sd || fault_s.ovp;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ilim_cnt_d[i] = ilim_cnt_q[i];
			if (!fault_s.sd_ilim[i]) begin
				ilim_cnt_d[i] = '0;
			end else if (ilim_cnt_q[i] != IW'(ILIM_CYC)) begin
				ilim_cnt_d[i] = ilim_cnt_q[i] + 1'b1;
			end
			ilim_deb[i] = (ilim_cnt_q[i] == IW'(ILIM_CYC));
			sd_below[i] = stepdown_enable_o[i] && (measured_mv_i[i] < `SHORT_LIMIT_MV);
			short_cnt_d[i] = short_cnt_q[i];
			if (!sd_below[i]) begin
				short_cnt_d[i] = '0;
			end else if (short_cnt_q[i] != SW'(SHORT_CYC)) begin
				short_cnt_d[i] = short_cnt_q[i] + 1'b1;
			end
			sd_trip[i]  = sd_below[i] && (short_cnt_q[i] == SW'(SHORT_CYC - 1));
			sd_off_d[i] = stepdown_enable_req_i[i] && (sd_off_q[i] || sd_trip[i]);
		end
		su_trip  = fault_s.su_short && stepup_enable_o;
		su_off_d = stepup_enable_req_i && (su_off_q || su_trip);
	end

	// Off latch holds until the request is withdrawn
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			ilim_cnt_q  <= '0;
			short_cnt_q <= '0;
			sd_off_q    <= '0;
			su_off_q    <= 1'b0;
		end else begin
			ilim_cnt_q  <= ilim_cnt_d;
			short_cnt_q <= short_cnt_d;
			sd_off_q    <= sd_off_d;
			su_off_q    <= su_off_d;
		end
	end

	// Shutdown faults act straight from the synchroniser, no extra stage
	assign stepdown_enable_o = stepdown_enable_req_i & ~sd_off_q
		& {2{!shutdown_all}};
	assign stepup_enable_o = stepup_enable_req_i && !su_off_q && !shutdown_all;
	assign general_purpose_outputs_low_o = shutdown_all;

	//------------------------------------------------------------
	// Start-up announcement
	//------------------------------------------------------------
	boot_state_t state_q, state_d;

	always_comb begin
		case (state_q)
			ST_BOOT:     state_d = ST_ANNOUNCE;
			ST_ANNOUNCE: state_d = ST_RUN;
			ST_RUN:      state_d = ST_RUN;
			default:     state_d = ST_BOOT;
		endcase
	end

	//------------------------------------------------------------
	// Event flags
	//------------------------------------------------------------
	logic [`RAIL_COUNT-1:0] rv_prev_q;
	logic [2:0]             rise, fall;
	flags_t                 set_v, hold_v, mask_v;
	logic [FW-1:0]          flag_v, pend_v;

	always_comb begin
		for (int k = 0; k < 3; k++) begin
			rise[k] = rv[k] && !rv_prev_q[k];
			fall[k] = !rv[k] && rv_prev_q[k];
		end
		set_v.sd_ilim   = ilim_deb;
		set_v.su_ilim   = fault_s.su_ilim;
		set_v.sd_short  = sd_trip;
		set_v.su_short  = su_trip;
		set_v.t_warn    = fault_s.t_warn;
		set_v.t_sd      = fault_s.t_sd;
		set_v.ovp       = fault_s.ovp;
		set_v.sd_good   = rise[1:0] | fall[1:0];
		set_v.su_good   = rise[`RAIL_SU] || fall[`RAIL_SU];
		set_v.reset_occ = (state_q == ST_ANNOUNCE);
		hold_v          = '0;
		hold_v.sd_ilim  = ilim_deb;
		hold_v.su_ilim  = fault_s.su_ilim;
		hold_v.t_warn   = fault_s.t_warn;
		hold_v.t_sd     = fault_s.t_sd;
		hold_v.ovp      = fault_s.ovp;
		mask_v          = '0; // Short, shutdown and overvoltage are unmaskable
		mask_v.sd_ilim  = masks_i.sd_ilim;
		mask_v.su_ilim  = masks_i.su_ilim;
		mask_v.t_warn   = masks_i.t_warn;
		for (int i = 0; i < 2; i++) begin
			mask_v.sd_good[i] = rise[i] ? masks_i.sd_rise[i] : masks_i.sd_fall[i];
		end
		mask_v.su_good   = rise[`RAIL_SU] ? masks_i.su_rise : masks_i.su_fall;
		mask_v.reset_occ = masks_i.reset_occ;
	end

	for (genvar f = 0; f < FW; f++) begin : g_flag
		event_flag u_flag (
			.clock_i   (clock_i),
			.reset_n_i (reset_n_i),
			.set_i     (set_v[f]),
			.hold_i    (hold_v[f]),
			.mask_i    (mask_v[f]),
			.clear_i   (clear_i[f]),
			.flag_o    (flag_v[f]),
			.pend_o    (pend_v[f])
		);
	end

	//------------------------------------------------------------
	// Group flags, interrupt line and registered outputs
	//------------------------------------------------------------
	flags_t     fl;
	logic [1:0] group_q, group_d;
	logic       irq_n_q, irq_n_d;
	mv_t        su_target_q;

	always_comb begin
		fl      = flags_t'(flag_v);
		group_d = {|{fl.sd_ilim, fl.sd_short, fl.sd_good},
			|{fl.su_ilim, fl.su_short, fl.su_good}};
		irq_n_d = !(|pend_v);
	end

	// One cycle behind the flags; puts the group flags, interrupt line and step-up target on flops
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state_q     <= ST_BOOT;
			rv_prev_q   <= '1;
			group_q     <= '0;
			irq_n_q     <= 1'b1;
			su_target_q <= '0;
		end else begin
			state_q     <= state_d;
			rv_prev_q   <= rv;
			group_q     <= group_d;
			irq_n_q     <= irq_n_d;
			su_target_q <= nom_mv[`RAIL_SU];
		end
	end

	assign flags_o                         = fl;
	assign stepdown_converter_group_flag_o = group_q[1];
	assign stepup_group_flag_o             = group_q[0];
	assign interrupt_out_n_o               = irq_n_q;
	assign stepup_target_mv_o              = su_target_q;
	assign rail_valid_o                    = rv;
	assign status_o = '{sd_ilim: ilim_deb, su_ilim: fault_s.su_ilim,
		t_warn: fault_s.t_warn, t_sd: fault_s.t_sd, ovp: fault_s.ovp,
		sd_good: rv[1:0], su_good: rv[`RAIL_SU]};

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_sd0_idle;
		!stepdown_enable_o[0] ##1 !stepdown_enable_o[0];
	endsequence

	a_irq_assert: assert property ((|pend_v) |=> !interrupt_out_n_o)
		else $error("interrupt not driven low on pending event");
	a_irq_release: assert property (!(|pend_v) |=> interrupt_out_n_o)
		else $error("interrupt low with nothing pending");
	a_boot_flag: assert property (state_q == ST_ANNOUNCE |=> flags_o.reset_occ)
		else $error("start-up did not set reset flag");
	a_ilim_early: assert property (!fault_s.sd_ilim[0] |=> !status_o.sd_ilim[0])
		else $error("current limit status without debounce");
	a_short_off: assert property (sd_trip[0] |=> !stepdown_enable_o[0])
		else $error("shorted step-down left enabled");
	a_su_short_off: assert property (su_trip |=> !stepup_enable_o)
		else $error("shorted step-up left enabled");
	a_tsd_all_off: assert property (fault_s.t_sd |->
		(stepdown_enable_o == 2'h0 && !stepup_enable_o && general_purpose_outputs_low_o))
		else $error("thermal shutdown left outputs on");
	a_ovp_all_off: assert property (fault_s.ovp |->
		(stepdown_enable_o == 2'h0 && !stepup_enable_o && general_purpose_outputs_low_o))
		else $error("overvoltage left outputs on");
	a_group_tracks: assert property ((|{fl.sd_ilim, fl.sd_short, fl.sd_good})
		|=> stepdown_converter_group_flag_o)
		else $error("group flag dropped with member set");
	a_gate_disabled: assert property (s_sd0_idle |=> rail_valid_o[0])
		else $error("disabled converter reported invalid");

endmodule // voltage_monitor_interrupt_logic
`default_nettype wire

// ### hw/vmi_regs.svh
// Constants of the supply monitor and interrupt logic
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef VMI_REGS_SVH
`define VMI_REGS_SVH

// Timing
`define CLK_PERIOD_NS    5
`define ILIM_DEBOUNCE_NS 20000
`define SHORT_TIME_NS    1000000

// Rail positions in the monitor vectors
`define RAIL_SU          2
`define RAIL_IN          3
`define RAIL_EXT0        4
`define RAIL_COUNT       6

// Levels in millivolts and window percentages
`define SHORT_LIMIT_MV   16'h015E
`define SD_WIN_BASE_MV   16'h001E
`define SD_WIN_STEP_MV   16'h0014
`define SU_NOM_BASE_MV   16'h1324
`define SU_NOM_STEP_MV   16'h0064
`define SU_PCT_BASE      7'h02
`define SU_PCT_STEP      7'h02
`define IN_NOM_LOW_MV    16'h0CE4
`define IN_NOM_HIGH_MV   16'h1388
`define EXT_NOM_MIN_MV   16'h028A
`define EXT_NOM_MAX_MV   16'h0708
`define EXT_NOM_STEP_MV  16'h0032
`define EXT_PCT_0        7'h02
`define EXT_PCT_1        7'h03
`define EXT_PCT_2        7'h04
`define EXT_PCT_3        7'h06

`endif

// ### hw/vmi_pkg.sv
// Types and helper arithmetic of the supply monitor and interrupt logic
`include "vmi_regs.svh"
package vmi_pkg;

	typedef logic [15:0] mv_t;

	// One bit per latched flag, also used for clear strobes
	typedef struct packed {
		logic [1:0] sd_ilim;
		logic       su_ilim;
		logic [1:0] sd_short;
		logic       su_short;
		logic       t_warn;
		logic       t_sd;
		logic       ovp;
		logic [1:0] sd_good;
		logic       su_good;
		logic       reset_occ;
	} flags_t;

	// Interrupt masks, high blocks the source from the interrupt line
	typedef struct packed {
		logic [1:0] sd_ilim;
		logic       su_ilim;
		logic       t_warn;
		logic [1:0] sd_rise;
		logic [1:0] sd_fall;
		logic       su_rise;
		logic       su_fall;
		logic       reset_occ;
	} masks_t;

	// Raw comparator levels from the analog side
	typedef struct packed {
		logic [1:0] sd_ilim;
		logic       su_ilim;
		logic       su_short;
		logic       t_warn;
		logic       t_sd;
		logic       ovp;
	} faults_t;

	// Live status bits
	typedef struct packed {
		logic [1:0] sd_ilim;
		logic       su_ilim;
		logic       t_warn;
		logic       t_sd;
		logic       ovp;
		logic [1:0] sd_good;
		logic       su_good;
	} status_t;

	typedef enum logic [1:0] {
		ST_BOOT     = 2'h0,
		ST_ANNOUNCE = 2'h1,
		ST_RUN      = 2'h3
	} boot_state_t;

	// Percentage of a nominal level, truncated to whole millivolts
	function automatic mv_t percent_mv(mv_t nom, logic [6:0] pct);
		logic [22:0] prod;
		prod = 23'(nom) * 23'(pct);
		return mv_t'(prod / 23'h64);
	endfunction

	// Window percentage table shared by external and input monitors
	function automatic logic [6:0] ext_pct(logic [1:0] code);
		case (code)
			2'h0:    return `EXT_PCT_0;
			2'h1:    return `EXT_PCT_1;
			2'h2:    return `EXT_PCT_2;
			default: return `EXT_PCT_3;
		endcase
	endfunction

endpackage

// ### hw/event_flag.sv
// Sticky write-one-to-clear flag with interrupt pending bit
`timescale 1ns/100ps
`default_nettype none
module event_flag
	import vmi_pkg::*;
(
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic reset_n_i,
	// Event side
	input  wire logic set_i,
	input  wire logic hold_i,
	input  wire logic mask_i,
	// Software side
	input  wire logic clear_i,
	output logic      flag_o,
	output logic      pend_o
);

	logic flag_q, flag_d;
	logic pend_q, pend_d;
	logic clr_ok;

	// Set beats clear; a live condition blocks the clear
	always_comb begin
		clr_ok = clear_i && !hold_i;
		flag_d = set_i || (flag_q && !clr_ok);
		pend_d = (set_i && !mask_i) || (pend_q && !clr_ok);
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			flag_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
			pend_q <= pend_d;
		end
	end

	assign flag_o = flag_q;
	assign pend_o = pend_q;

	a_set_wins: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		set_i |=> flag_o)
		else $error("flag lost an event during a clear");

	a_hold_blocks: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(flag_o && hold_i) |=> flag_o)
		else $error("flag cleared while condition active");

endmodule // event_flag
`default_nettype wire

// ### hw/window_check.sv
// Window comparator for one monitored rail
`timescale 1ns/100ps
`default_nettype none
module window_check
	import vmi_pkg::*;
(
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic reset_n_i,
	// Settings
	input  wire logic active_i,
	input  wire logic window_type_i,
	input  wire mv_t  nominal_i,
	input  wire mv_t  window_i,
	// Measurement and result
	input  wire mv_t  measured_i,
	output logic      valid_o
);

	logic        valid_q, valid_d;
	logic [16:0] low_lim, high_lim;

	// Limits widened by one bit so the sums cannot wrap
	always_comb begin
		low_lim  = (nominal_i > window_i) ? 17'(nominal_i - window_i) : 17'h0;
		high_lim = 17'(nominal_i) + 17'(window_i);
		valid_d  = !active_i
			|| ((17'(measured_i) >= low_lim)
			&& (!window_type_i || 17'(measured_i) <= high_lim));
	end

	// Idle monitor reads valid so it never drops power-good
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			valid_q <= 1'b1;
		end else begin
			valid_q <= valid_d;
		end
	end

	assign valid_o = valid_q;

	a_under_only: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(active_i && !window_type_i && measured_i >= nominal_i) |=> valid_o)
		else $error("overvoltage flagged in undervoltage-only mode");

endmodule // window_check
`default_nettype wire

// ### testbench/host_model.sv
// Host processor model that polls and clears the flags and sets monitor codes
`timescale 1ns/100ps
`default_nettype none
module host_model
	import vmi_pkg::*;
#(
	parameter int DELAY = 3
) (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       reset_n_i,
	// Control from the bench
	input  wire logic       service_i,
	input  wire logic       divider_i,
	// Device side
	input  wire flags_t     flags_i,
	output flags_t          clear_o,
	output logic [1:0][4:0] extmon_code_o
);
	// ----------------------------------------
	// Polling service
	// ----------------------------------------
	int count_q;

	// Clear pulses last one cycle; a slow host is a larger DELAY
	always_ff @(posedge clock_i) begin
		clear_o <= '0;
		if (!reset_n_i) begin
			count_q <= 0;
		end else if (service_i && (|flags_i)) begin
			count_q <= (count_q == DELAY) ? 0 : count_q + 1;
			if (count_q == DELAY) begin
				clear_o <= flags_i;
			end
		end
	end

	// Divider fitted means lowest code, which makes the pin high-Z
	assign extmon_code_o = divider_i ? '0 : {5'h17, 5'h17};
endmodule // host_model
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench of the supply monitor and interrupt logic
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s expected %0h seen %0h", nm, e, g); end end
module testbench
	import vmi_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic             clock_i, reset_n_i, wtype, su_req, service, divider, gpo_low, int_n;
	logic [5:0]       mon_en, valid;
	logic [1:0]       su_vset, sd_req, sd_en, high_z, su_win, in_win;
	logic             su_en, sd_grp, su_grp, in_sel;
	logic [1:0][4:0]  ext_code;
	logic [1:0][7:0]  sd_vset;
	mv_t [5:0]        meas;
	mv_t              target;
	faults_t          faults;
	masks_t           masks;
	flags_t           flags, clr;
	status_t          status;
	int               failures, n_compared;

	voltage_monitor_interrupt_logic #(.SHORT_TIME_NS(500)) dut (.clock_i(clock_i),
		.reset_n_i(reset_n_i), .window_type_select_i(wtype),
		.monitor_enable_control_i(mon_en), .stepdown_voltage_setting_i(sd_vset),
		.stepdown_window_select_i('0), .stepup_voltage_setting_i(su_vset),
		.stepup_window_select_i(su_win), .input_nominal_select_i(in_sel),
		.input_window_select_i(in_win), .extmon_nominal_select_i(ext_code),
		.extmon_window_select_i('0), .measured_mv_i(meas), .faults_i(faults),
		.stepdown_enable_req_i(sd_req), .stepup_enable_req_i(su_req),
		.stepdown_enable_o(sd_en), .stepup_enable_o(su_en),
		.general_purpose_outputs_low_o(gpo_low), .stepup_target_mv_o(target),
		.extmon_high_z_o(high_z), .rail_valid_o(valid), .clear_i(clr), .masks_i(masks),
		.flags_o(flags), .status_o(status), .stepdown_converter_group_flag_o(sd_grp),
		.stepup_group_flag_o(su_grp), .interrupt_out_n_o(int_n));

	host_model host (.clock_i(clock_i), .reset_n_i(reset_n_i), .service_i(service),
		.divider_i(divider), .flags_i(flags), .clear_o(clr), .extmon_code_o(ext_code));

	// ----------------------------------------
	// Clock, tasks and watchdog
	// ----------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Run is about 4330 cycles, mostly the limit debounce; 6000 means a hang
	initial begin
		repeat (6000) @(posedge clock_i);
		failures++;
		results();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{reset_n_i, wtype, su_req, service, divider, mon_en, su_vset, sd_req} = '0;
		{meas, faults, masks, failures, n_compared, sd_vset, su_win, in_sel, in_win} = '0;
		tick(4);
		@(posedge clock_i) reset_n_i <= 1'b1;
		tick(6);
		`CHK("reset flag", 1'b1, flags.reset_occ)
		`CHK("int low", 1'b0, int_n)
		@(posedge clock_i) service <= 1'b1;
		tick(10);
		`CHK("int high", 1'b1, int_n)
		$display("test start-up done");
		// Clear refused while the warning is held
		@(posedge clock_i) faults.t_warn <= 1'b1;
		tick(12);
		`CHK("warn flag", 1'b1, flags.t_warn)
		`CHK("warn status", 1'b1, status.t_warn)
		@(posedge clock_i) faults.t_warn <= 1'b0;
		tick(12);
		`CHK("warn cleared", 1'b0, flags.t_warn)
		// Masked warning sets its flag but leaves the line high
		@(posedge clock_i) {service, masks.t_warn, faults.t_warn} <= 3'b011;
		@(posedge clock_i) faults.t_warn <= 1'b0;
		tick(8);
		`CHK("masked flag", 1'b1, flags.t_warn)
		`CHK("masked int", 1'b1, int_n)
		@(posedge clock_i) {service, masks.t_warn} <= 2'b10;
		$display("test warning done");
		// Overvoltage takes converters down while held
		@(posedge clock_i) {su_req, faults.ovp} <= 2'b11;
		tick(6);
		`CHK("ovp enable", 1'b0, su_en)
		`CHK("ovp gpo", 1'b1, gpo_low)
		`CHK("ovp flag", 1'b1, flags.ovp)
		@(posedge clock_i) faults.ovp <= 1'b0;
		tick(12);
		`CHK("ovp back", 1'b1, su_en)
		`CHK("ovp cleared", 1'b0, flags.ovp)
		$display("test overvoltage done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clock_i) su_vset <= 2'(i);
			tick(3);
			`CHK("target", 16'(16'h1324 + i * 16'h0064), target)
		end
		$display("test step-up target done");
		// Step-up rail at 5000 mV with a 2 percent window
		@(posedge clock_i) {service, mon_en[2], su_vset, meas[2]} <= {2'b01, 2'h1, 16'h1388};
		tick(8);
		@(posedge clock_i) meas[2] <= 16'h141E;
		tick(8);
		`CHK("under only", 1'b1, valid[2])
		@(posedge clock_i) wtype <= 1'b1;
		tick(8);
		`CHK("over valid", 1'b0, valid[2])
		`CHK("good flag", 1'b1, flags.su_good)
		`CHK("good status", 1'b0, status.su_good)
		`CHK("group set", 1'b1, su_grp)
		@(posedge clock_i) {service, meas[2]} <= {1'b1, 16'h1388};
		tick(12);
		`CHK("group clear", 1'b0, su_grp)
		$display("test step-up good done");
		// 4 percent step-up window; input rail at 5 V with a 6 percent window
		@(posedge clock_i) {su_win, meas[2], meas[3], in_sel, in_win, mon_en[3]} <=
			{2'h1, 16'h1450, 16'h128E, 4'hF};
		tick(8);
		`CHK("wide windows", 2'b11, valid[3:2])
		@(posedge clock_i) meas[3] <= 16'h122A;
		tick(8);
		`CHK("input under", 1'b0, valid[3])
		$display("test windows done");
		@(posedge clock_i) faults.su_short <= 1'b1;
		tick(6);
		`CHK("su short off", 1'b0, su_en)
		@(posedge clock_i) {faults.su_short, su_req, service, sd_req[0]} <= 4'b0001;
		tick(110);
		`CHK("sd short off", 1'b0, sd_en[0])
		`CHK("sd short flag", 1'b1, flags.sd_short[0])
		`CHK("sd group", 1'b1, sd_grp)
		@(posedge clock_i) {sd_req[0], service, divider} <= 3'b011;
		tick(12);
		`CHK("shorts clear", 2'b00, {flags.sd_short[0], flags.su_short})
		`CHK("high-z", 2'b11, high_z)
		$display("test shorts done");
		// Held faults refuse the clear; step-down limit waits out its debounce
		@(posedge clock_i) {faults.sd_ilim[0], faults.su_ilim, faults.t_sd} <= 3'b111;
		tick(6);
		`CHK("tsd gpo", 1'b1, gpo_low)
		`CHK("ilim early", 1'b0, status.sd_ilim[0])
		tick(4004);
		`CHK("held flags", 3'b111, {flags.sd_ilim[0], flags.su_ilim, flags.t_sd})
		`CHK("ilim status", 1'b1, status.sd_ilim[0])
		`CHK("ilim groups", 2'b11, {sd_grp, su_grp})
		@(posedge clock_i) {faults.sd_ilim[0], faults.su_ilim, faults.t_sd} <= 3'b000;
		tick(12);
		`CHK("limits clear", 3'b000, {flags.sd_ilim[0], flags.su_ilim, flags.t_sd})
		$display("test held faults done");
		// Step-down rail at 1200 mV with a 30 mV window, then 50 mV low
		@(posedge clock_i) {service, sd_vset[0], meas[0], mon_en[0], sd_req[0]} <=
			{1'b0, 8'h78, 16'h04B0, 2'b11};
		tick(8);
		`CHK("sd in window", 1'b1, valid[0])
		@(posedge clock_i) meas[0] <= 16'h047E;
		tick(8);
		`CHK("sd good status", 1'b0, status.sd_good[0])
		`CHK("sd good flag", 1'b1, flags.sd_good[0])
		`CHK("sd good int", 1'b0, int_n)
		$display("test step-down good done");
		results();
	end
endmodule // testbench
`default_nettype wire
